/* File: hdl/rcc_top.sv */
// collision position capture with ahb-lite register slave
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/100ps
`include "rcc_consts.svh"
module rcc_top import rcc_pkg::*; (
  input  wire logic        ref_clk_i,   // 25 mhz system clock
  input  wire logic        reset_i,     // synchronous, active high
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire rcc_rx_t     rx_i,        // decoder strobes, same clock
  output logic             rx_bit_o,    // bit value after clearing
  output logic             rx_bit_valid_o,
  output logic             irq_o
);
  // capture and register state
  rcc_state_t  state_reg;          // capture state
  logic        keep_reg;           // keep_bits_after_collision
  logic        invalid_reg;        // collision_position_invalid
  logic [4:0]  pos_reg;            // collision_bit_position
  logic [5:0]  count_reg;          // data bits seen, saturating
  logic        seen_reg;           // a collision already captured
  logic [1:0]  stat_reg;           // sticky interrupt status
  logic [1:0]  mask_reg;           // interrupt enables
  logic        wr_pend_reg;        // write data phase pending
  logic        rd_pend_reg;        // read data phase pending
  logic [31:0] addr_reg;           // latched address
  logic [5:0]  count_next;         // position of the incoming bit
  logic        coll_hit;           // first collision this bit
  logic        stat_rd;            // status read clears
  logic        access;             // valid address phase
  logic        bit_evt;            // a data bit inside a frame
  logic        end_evt;            // a frame closes normally
  logic [1:0]  stat_clr;           // status bits that software has seen

  // a data strobe only counts while a frame is open; a stray strobe
  // between frames must not move the position counter
  function automatic logic frame_bit(input rcc_state_t st, input rcc_rx_t rx);
    return (st == RCC_RECV) && rx.valid;
  endfunction : frame_bit

  // an end pulse outside a frame is ignored, so no spurious done event
  function automatic logic frame_end(input rcc_state_t st, input rcc_rx_t rx);
    return (st == RCC_RECV) && rx.done;
  endfunction : frame_end

  // register select, shared by the write decode and the read-clear logic
  function automatic logic reg_hit(input logic [31:0] addr, input logic [31:0] offset);
    return addr == offset;
  endfunction : reg_hit

  // saturating increment keeps a very long frame from wrapping back into range
  function automatic logic [5:0] sat_inc(input logic [5:0] cnt);
    return (cnt == `RCC_POS_MAX) ? cnt : cnt + 6'h01;
  endfunction : sat_inc

  // address phase accepted this edge; hready low means another slave stalls
  assign access     = hsel_i && hready_i && (htrans_i == `RCC_HTRANS_NONSEQ);
  assign count_next = sat_inc(count_reg);
  assign bit_evt    = frame_bit(state_reg, rx_i);
  assign end_evt    = frame_end(state_reg, rx_i);
  assign coll_hit   = bit_evt && rx_i.collision && !seen_reg;
  assign stat_rd    = rd_pend_reg && reg_hit(addr_reg, `RCC_OFF_IRQ_STAT);
  // only the bits captured into the read data are cleared; an event that
  // lands between the address phase and the data phase survives the read
  assign stat_clr   = stat_rd ? hrdata_o[1:0] : 2'h0;

  // capture state: a start always restarts, even mid frame
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_reg <= RCC_IDLE;
    end else if (rx_i.start) begin
      state_reg <= RCC_RECV;
    end else begin
      unique case (state_reg)
        RCC_IDLE: begin
          state_reg <= RCC_IDLE; // wait for the next start pulse
        end
        RCC_RECV: begin
          if (rx_i.done) begin
            state_reg <= RCC_IDLE; // frame closed
          end
        end
      endcase
    end
  end

  // data bit counter, only data strobes count
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || rx_i.start) begin
      count_reg <= 6'h00;
    end else if (bit_evt) begin
      // past the thirty-second bit the count sticks, which marks out of range
      count_reg <= count_next;
    end
  end

  // first collision capture and validity
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      invalid_reg <= `RCC_RESET_INVALID;
      // position has no defined reset value; zero keeps the bus free of x
      pos_reg     <= 5'h00;
      seen_reg    <= 1'b0;
    end else if (rx_i.start) begin
      // a new frame forgets the report of the last one
      invalid_reg <= 1'b1;
      seen_reg    <= 1'b0;
    end else if (coll_hit) begin
      // later collisions in the same frame leave the report alone
      seen_reg    <= 1'b1;
      // truncation maps 32 to 00h; beyond 32 stays invalid
      pos_reg     <= count_next[4:0];
      invalid_reg <= (count_next == `RCC_POS_MAX + 6'h01) || (count_reg == `RCC_POS_MAX);
    end
  end

  // received bit output, cleared after collision unless kept
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rx_bit_o       <= 1'b0;
      rx_bit_valid_o <= 1'b0;
    end else begin
      // one cycle of latency keeps both outputs straight from flops
      rx_bit_valid_o <= bit_evt;
      // the colliding bit itself and all later ones are zeroed
      rx_bit_o       <= rx_i.data && (keep_reg || !(seen_reg || coll_hit));
    end
  end

  // control and interrupt mask registers, the only software writable bits here
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      keep_reg <= `RCC_RESET_KEEP;
      mask_reg <= 2'h0;
    end else if (wr_pend_reg && reg_hit(addr_reg, `RCC_OFF_COLL)) begin
      // flag and position are read only, so only the keep bit is taken
      keep_reg <= hwdata_i[`RCC_BIT_KEEP];
    end else if (wr_pend_reg && reg_hit(addr_reg, `RCC_OFF_IRQ_MASK)) begin
      // bits above the two events are not stored
      mask_reg <= hwdata_i[1:0];
    end
  end

  // sticky status, a new event wins over a read clear
  // the clear uses the returned snapshot, not the live bits
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      stat_reg <= 2'h0;
    end else begin
      // first collision of a frame
      stat_reg[`RCC_IRQ_COLL] <= coll_hit || (stat_reg[`RCC_IRQ_COLL] && !stat_clr[`RCC_IRQ_COLL]);
      // frame closed by its end pulse
      stat_reg[`RCC_IRQ_DONE] <= end_evt || (stat_reg[`RCC_IRQ_DONE] && !stat_clr[`RCC_IRQ_DONE]);
    end
  end

  // level interrupt output
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
    end else begin
      // computed from the next status value so the pin has no extra lag
      // behind the sticky bits, and still comes straight from a flop
      irq_o <= |(((stat_reg & ~stat_clr) | {end_evt, coll_hit}) & mask_reg);
    end
  end

  // ahb address phase capture, zero wait state
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= 32'h0000_0000;
    end else begin
      // hsize is ignored: every register is one aligned word
      wr_pend_reg <= access && hwrite_i;
      rd_pend_reg <= access && !hwrite_i;
      // the address is kept for the data phase, where write data lands
      if (access) begin
        addr_reg <= haddr_i;
      end
    end
  end

  // read data, registered one cycle after the address phase
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      hrdata_o    <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      // no wait states: the answer always comes in the next cycle
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0; // always okay, unmapped reads zero
      // sampled in the address phase so the value stands through the data phase
      if (access && !hwrite_i) begin
        case (haddr_i)
          // reserved bit 6 always reads zero
          `RCC_OFF_COLL:     hrdata_o <= {24'h0, keep_reg, 1'b0, invalid_reg, pos_reg};
          `RCC_OFF_IRQ_STAT: hrdata_o <= {30'h0, stat_reg};
          `RCC_OFF_IRQ_MASK: hrdata_o <= {30'h0, mask_reg};
          default:           hrdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule : rcc_top

/* File: hdl/rcc_consts.svh */
// constants for the collision position capture block
`ifndef RCC_CONSTS_SVH
`define RCC_CONSTS_SVH
// the report register is known by its word index; its byte address is four times that
`define RCC_IDX_COLL      8'h0e
`define RCC_OFF_COLL      32'h0000_0038
`define RCC_OFF_IRQ_STAT  32'h0000_0010
`define RCC_OFF_IRQ_MASK  32'h0000_0014
`define RCC_BIT_KEEP      7
`define RCC_BIT_INVALID   5
`define RCC_POS_MAX       6'h20
`define RCC_RESET_KEEP    1'b1
`define RCC_RESET_INVALID 1'b1
`define RCC_IRQ_COLL      0
`define RCC_IRQ_DONE      1
`define RCC_HTRANS_NONSEQ 2'h2
`endif

/* File: hdl/rcc_pkg.sv */
// types for the collision position capture block
package rcc_pkg;
  // decoder strobes for one cycle: frame start, one data bit, frame end
  typedef struct packed {
    logic start;     // frame start pulse
    logic valid;     // data bit strobe
    logic data;      // decoded bit value
    logic collision; // bit carried a collision
    logic done;      // frame end pulse
  } rcc_rx_t;
  // capture state
  typedef enum logic [1:0] {
    RCC_IDLE = 2'b01,
    RCC_RECV = 2'b10
  } rcc_state_t;
endpackage : rcc_pkg

/* File: dv/rcc_checker.sv */
// port assertions for the capture block
`timescale 1ns/100ps
`include "rcc_consts.svh"
module rcc_checker import rcc_pkg::*; (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  input  wire logic        hsel_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic        hready_i,
  input  wire rcc_rx_t     rx_i,
  input  wire logic        rx_bit_o,
  input  wire logic        rx_bit_valid_o,
  input  wire logic [31:0] hrdata_o,
  input  wire logic        hreadyout_o,
  input  wire logic        hresp_o,
  input  wire logic        irq_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  // one decoded bit enters
  sequence s_bit; rx_i.valid; endsequence
  chk_bit_strobe:
    assert property (s_bit |=> rx_bit_valid_o) else $error("bit strobe lost");
  chk_no_strobe:
    assert property (!rx_i.valid |=> !rx_bit_valid_o) else $error("spurious strobe");
  chk_clear_only:
    assert property (s_bit |=> !rx_bit_o || $past(rx_i.data)) else $error("bit set");
  chk_bus_okay:
    assert property (hreadyout_o && !hresp_o) else $error("bus stalled or error");
  // a frame opens and its first data bit follows
  sequence s_frame_open; rx_i.start ##1 rx_i.valid; endsequence
  chk_first_bit:
    assert property (s_frame_open |=> rx_bit_valid_o) else $error("first bit of frame lost");
  chk_rdata_stands:
    assert property (!(hsel_i && hready_i && htrans_i == `RCC_HTRANS_NONSEQ && !hwrite_i)
      |=> $stable(hrdata_o)) else $error("read data moved without a read");
  chk_reset_quiet:
    assert property ($fell(reset_i) |-> !irq_o && !rx_bit_valid_o && hrdata_o == 32'h0)
      else $error("outputs busy after reset");
endmodule : rcc_checker
bind rcc_top rcc_checker i_chk (.*);

/* File: dv/rcc_rx_model.sv */
// card side: sends frames of ones with at most one colliding bit
`timescale 1ns/100ps
module rcc_rx_model import rcc_pkg::*; (
  input  wire logic ref_clk_i,
  output rcc_rx_t   rx_o
);
  initial rx_o = '0;
  // c of zero means a clean frame
  task automatic frame(input int n, c);
    @(posedge ref_clk_i) rx_o <= 5'h10;
    for (int i = 1; i <= n; i++) begin
      @(posedge ref_clk_i) rx_o <= {2'b01, 1'b1, i == c, 1'b0};
    end
    @(posedge ref_clk_i) rx_o <= 5'h01;
    @(posedge ref_clk_i) rx_o <= '0;
  endtask : frame
endmodule : rcc_rx_model

/* File: dv/rcc_top_tb.sv */
// bench for the collision capture block
`timescale 1ns/100ps
`include "rcc_consts.svh"
module rcc_top_tb import rcc_pkg::*; ;
  logic        ref_clk_i = 0, reset_i = 1, hsel = 0, hwr = 0, irq, rbit, rvld, hrdy, hresp;
  logic [1:0]  htr = 0;
  logic [31:0] hadr = 0, hwd = 0, hrd, rd;
  rcc_rx_t     rx;
  int          err_count = 0, check_count = 0, cyc = 0, ones = 0;
  always #20 ref_clk_i = ~ref_clk_i;
  rcc_top i_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .hsel_i(hsel), .haddr_i(hadr),
    .htrans_i(htr), .hwrite_i(hwr), .hsize_i(3'h2), .hwdata_i(hwd), .hready_i(hrdy),
    .hrdata_o(hrd), .hreadyout_o(hrdy), .hresp_o(hresp), .rx_i(rx), .rx_bit_o(rbit),
    .rx_bit_valid_o(rvld), .irq_o(irq));
  rcc_rx_model m (.ref_clk_i(ref_clk_i), .rx_o(rx));
  // count surviving ones; a hang ends the run
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (rvld === 1'b1 && rbit === 1'b1) ones <= ones + 1;
    if (cyc == 5000) begin err_count++; stop_test; end
  end
  task automatic chk(input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin err_count++; $display("BAD %0t seen %h want %h", $time, s, e); end
  endtask : chk
  task automatic ahb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    @(posedge ref_clk_i) {hsel, htr, hwr, hadr} <= {1'b1, `RCC_HTRANS_NONSEQ, w, a};
    do @(posedge ref_clk_i); while (hrdy !== 1'b1);
    {hsel, htr, hwd} <= {1'b0, 2'h0, d};
    do @(posedge ref_clk_i); while (hrdy !== 1'b1);
    r = hrd;
  endtask : ahb
  // one frame, then the report and the ones count
  task automatic t_frame(input int n, c, input logic [31:0] k, e, input int o);
    ones = 0;
    m.frame(n, c);
    ahb(0, `RCC_OFF_COLL, 0, rd);
    chk(rd & k, e);
    chk(ones, o);
  endtask : t_frame
  task automatic t_reset;
    ahb(0, `RCC_OFF_COLL, 0, rd);
    chk(rd, 32'h0000_00a0);
    ahb(1, `RCC_OFF_COLL, 32'h0000_007f, rd);
    ahb(0, `RCC_OFF_COLL, 0, rd);
    chk(rd, 32'h0000_0020);
    ahb(1, `RCC_OFF_COLL, 32'h0000_0080, rd);
    ahb(0, 32'h0000_0040, 0, rd);
    chk(rd, 32'h0); // unmapped
  endtask : t_reset
  task automatic t_position;
    t_frame(40, 1, 32'hff, 32'h81, 40);
    t_frame(40, 8, 32'hff, 32'h88, 40);
    t_frame(40, 32, 32'hff, 32'h80, 40);
  endtask : t_position
  task automatic t_invalid;
    t_frame(10, 0, 32'he0, 32'ha0, 10);
    t_frame(40, 33, 32'he0, 32'ha0, 40);
  endtask : t_invalid
  task automatic t_clear;
    ahb(1, `RCC_OFF_COLL, 32'h0, rd);
    t_frame(10, 4, 32'hff, 32'h04, 3);
    ahb(1, `RCC_OFF_COLL, 32'h0000_0080, rd);
  endtask : t_clear
  // enable the collision event, raise it, clear it by reading, then the same for frame end
  task automatic t_irq;
    ahb(0, `RCC_OFF_IRQ_STAT, 0, rd);
    chk(irq, 1'b0);
    ahb(1, `RCC_OFF_IRQ_MASK, 32'h1, rd);
    ahb(0, `RCC_OFF_IRQ_MASK, 0, rd);
    chk(rd, 32'h1);
    t_frame(10, 2, 32'hff, 32'h82, 10);
    chk(irq, 1'b1);
    ahb(0, `RCC_OFF_IRQ_STAT, 0, rd);
    chk(rd, 32'h3);
    repeat (2) @(posedge ref_clk_i);
    chk(irq, 1'b0);
    // only the frame end event is enabled now
    ahb(1, `RCC_OFF_IRQ_MASK, 32'h2, rd);
    t_frame(10, 0, 32'he0, 32'ha0, 10);
    chk(irq, 1'b1);
    ahb(0, `RCC_OFF_IRQ_STAT, 0, rd);
    chk(rd, 32'h2);
    repeat (2) @(posedge ref_clk_i);
    chk(irq, 1'b0);
  endtask : t_irq
  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  initial begin
    repeat (20) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    t_reset;
    t_position;
    t_invalid;
    t_clear;
    t_irq;
    stop_test;
  end
endmodule : rcc_top_tb
